//--- hw/ssp_top.v
/*
  spi mode of the synchronous serial port, axi4-lite register slave,
  eight word transmit queue. assumes pins asynchronous to clk and an
  outside pad that resolves the pin enables.
*/
// The address map and the AXI4-Lite register port were left to the implementer.
//
// Contract
// - shift eight bits in and out, all modes
// - optional slave select input in slave operation
// - shifter reached only through the buffer
// - control rw; status upper two rw, rest ro
// - receive double buffered via buffer register
// - full word copies to buffer, sets flag
// - buffer write loads buffer and shifter both
// - master sample point: end or middle
// - edge bit picks output change transition
// - stop bit cleared while port disabled
// - buffer full bit shows unread word
// - write while busy sets write collision
// - slave word onto full buffer: overflow
`timescale 1ns/10ps
`include "ssp_regs.vh"
module ssp_top (
  input wire clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe,
  input wire sdi_i,
  output wire sdo_o,
  output wire sdo_oe,
  input wire ss_n_i
);
  reg smp_reg;
  reg cke_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] buf_reg;
  reg bf_reg;
  reg irq_reg;
  reg [7:0] tx_reg;
  reg [7:0] shift_reg;
  reg busy_reg;
  reg pend_reg;
  reg [4:0] edge_reg;
  reg [6:0] div_reg;
  reg sck_reg;
  reg sdo_reg;
  reg [2:0] optr_reg;
  reg [2:0] icnt_reg;
  reg sck_d_reg;
  reg aw_ok_reg;
  reg [7:0] awaddr_reg;
  reg w_ok_reg;
  reg [7:0] wdata_reg;
  reg wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [31:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [7:0] ctrl_next;
  reg [31:0] rdata_next;
  reg [6:0] half_m1;
  localparam [7:0] RST_STATUS = `SSP_RST_STATUS;
  localparam [2:0] RST_PINS = `SSP_RST_PINS;

  wire [2:0] pin_q;
  wire sck_q = pin_q[0];
  wire sdi_q = pin_q[1];
  wire ss_n_q = pin_q[2];
  wire [3:0] mode = ctrl_reg[`SSP_CT_MODE_HI:`SSP_CT_MODE_LO];
  wire en = ctrl_reg[`SSP_CT_EN];
  wire cpol = ctrl_reg[`SSP_CT_CPOL];
  wire master = (mode[3:2] == 2'b00);
  wire use_ss = (mode == `SSP_MODE_SLV_SS);
  wire slave = use_ss | (mode == `SSP_MODE_SLV_NOSS);

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `SSP_OFF_STATUS) | (a == `SSP_OFF_CONTROL) |
        (a == `SSP_OFF_BUFFER) | (a == `SSP_OFF_FLAGS) |
        (a == `SSP_OFF_QUEUE);
    end
  endfunction

  ssp_sync #(
    .WIDTH(3),
    .RESET_VAL(`SSP_RST_PINS)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({ss_n_i, sdi_i, sck_i}),
    .dout(pin_q)
  );

  // register bus write side
  wire q_sel = (awaddr_reg == `SSP_OFF_QUEUE);
  wire wr_ready = aw_ok_reg & w_ok_reg & ~bvalid_reg;
  wire fifo_in_valid = wr_ready & q_sel & wstrb_reg;
  wire fifo_in_ready;
  wire do_wr = wr_ready & ~(q_sel & wstrb_reg & ~fifo_in_ready);
  wire wr_en = do_wr & wstrb_reg;
  wire wr_buf = wr_en & (awaddr_reg == `SSP_OFF_BUFFER);
  wire wr_ctrl = wr_en & (awaddr_reg == `SSP_OFF_CONTROL);
  wire wr_stat = wr_en & (awaddr_reg == `SSP_OFF_STATUS);
  wire wr_flag = wr_en & (awaddr_reg == `SSP_OFF_FLAGS);
  wire do_rd = s_axi_arvalid & ~rvalid_reg;
  wire rd_buf = do_rd & (s_axi_araddr == `SSP_OFF_BUFFER);

  // transmit queue drains into the shifter between words
  wire [7:0] fifo_data;
  wire fifo_out_valid;
  wire [3:0] fifo_level;
  wire fifo_out_ready = en & (master | slave) & ~wr_buf & ~busy_reg &
    ~pend_reg;
  wire pop = fifo_out_valid & fifo_out_ready;

  ssp_fifo #(
    .WIDTH(`SSP_FIFO_WIDTH),
    .DEPTH(`SSP_FIFO_DEPTH),
    .AW(`SSP_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(wdata_reg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_data),
    .level(fifo_level)
  );

  wire write_collision_set = wr_buf & busy_reg;
  wire load = (wr_buf & ~busy_reg) | pop;
  wire [7:0] load_data = wr_buf ? wdata_reg : fifo_data;

  // master clock divider and edge numbering
  always @*
  begin
    case (mode[1:0])
      2'b00: half_m1 = `SSP_HALF_DIV4;
      2'b01: half_m1 = `SSP_HALF_DIV16;
      2'b10: half_m1 = `SSP_HALF_DIV64;
      default: half_m1 = `SSP_HALF_DIV128;
    endcase
  end

  wire m_run = en & master & busy_reg;
  wire tick = m_run & (div_reg == half_m1);
  wire [4:0] edge_n = edge_reg + 5'h01;
  wire [4:0] last_m = (!cke_reg && smp_reg) ? `SSP_EDGES_END : `SSP_EDGES;
  wire m_done = tick & (edge_n == last_m);

  // slave clock edges from the synchronised pin
  wire s_act = en & slave & ~(use_ss & ss_n_q);
  wire s_rise = sck_q & ~sck_d_reg;
  wire s_fall = ~sck_q & sck_d_reg;
  wire s_ev = s_act & (s_rise | s_fall);
  wire s_lead = cpol ? s_fall : s_rise;

  wire ev = tick | s_ev;
  wire lead = master ? edge_n[0] : s_lead;
  wire m_late = master & (edge_n >= `SSP_EDGES);
  wire chg = ev & (cke_reg ? ~lead : lead) & ~m_late;
  wire end_pt = cke_reg ? ~lead :
    (lead & (edge_n >= `SSP_FIRST_END_SAMPLE));
  wire mid_pt = cke_reg ? lead : ~lead;
  wire smp_ev = ev & ((master & smp_reg) ? end_pt : mid_pt);
  wire word_done = smp_ev & (icnt_reg == 3'h7);
  wire ovf_set = word_done & slave & bf_reg;
  wire buf_take = word_done & ~ovf_set;

  always @*
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = wdata_reg;
    if (write_collision_set)
      ctrl_next[`SSP_CT_WRITE_COLLISION] = 1'b1;
    if (ovf_set)
      ctrl_next[`SSP_CT_OVF] = 1'b1;
  end

  always @*
  begin
    rdata_next = 32'h00000000;
    case (s_axi_araddr)
      `SSP_OFF_STATUS:
      begin
        rdata_next[`SSP_ST_SAMPLE] = smp_reg;
        rdata_next[`SSP_ST_EDGE] = cke_reg;
        rdata_next[`SSP_ST_STOP] = 1'b0;
        rdata_next[`SSP_ST_FULL] = bf_reg;
      end
      `SSP_OFF_CONTROL: rdata_next[7:0] = ctrl_reg;
      `SSP_OFF_BUFFER: rdata_next[7:0] = buf_reg;
      `SSP_OFF_FLAGS:
      begin
        rdata_next[`SSP_FL_IRQ] = irq_reg;
        rdata_next[`SSP_FL_BUSY] = busy_reg;
        rdata_next[`SSP_FL_LVL_LO+3:`SSP_FL_LVL_LO] = fifo_level;
      end
      default: rdata_next = 32'h00000000;
    endcase
  end

  // register bus state
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_ok_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_ok_reg <= 1'b0;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `SSP_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `SSP_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_ok_reg)
      begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_ok_reg)
      begin
        w_ok_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end
      if (do_wr)
      begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(awaddr_reg) ? `SSP_RESP_OKAY :
          `SSP_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
      if (do_rd)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rdata_next;
        rresp_reg <= mapped(s_axi_araddr) ? `SSP_RESP_OKAY :
          `SSP_RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // port registers and shift engine
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      smp_reg <= RST_STATUS[`SSP_ST_SAMPLE];
      cke_reg <= RST_STATUS[`SSP_ST_EDGE];
      ctrl_reg <= `SSP_RST_CONTROL;
      buf_reg <= 8'h00;
      bf_reg <= 1'b0;
      irq_reg <= 1'b0;
      tx_reg <= 8'h00;
      shift_reg <= 8'h00;
      busy_reg <= 1'b0;
      pend_reg <= 1'b0;
      edge_reg <= 5'h00;
      div_reg <= 7'h00;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      optr_reg <= 3'h7;
      icnt_reg <= 3'h0;
      sck_d_reg <= RST_PINS[0];
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      sck_d_reg <= sck_q;
      if (wr_stat)
      begin
        smp_reg <= wdata_reg[`SSP_ST_SAMPLE];
        cke_reg <= wdata_reg[`SSP_ST_EDGE];
      end
      if (buf_take)
        buf_reg <= {shift_reg[6:0], sdi_q};
      else if (load)
        buf_reg <= load_data;
      if (buf_take)
        bf_reg <= 1'b1;
      else if (rd_buf)
        bf_reg <= 1'b0;
      if (word_done)
        irq_reg <= 1'b1;
      else if (wr_flag & wdata_reg[`SSP_FL_IRQ])
        irq_reg <= 1'b0;
      if (smp_ev)
      begin
        shift_reg <= {shift_reg[6:0], sdi_q};
        icnt_reg <= icnt_reg + 3'h1;
      end
      if (chg)
      begin
        sdo_reg <= tx_reg[optr_reg];
        optr_reg <= optr_reg - 3'h1;
      end
      if (m_run)
        div_reg <= tick ? 7'h00 : div_reg + 7'h01;
      if (tick)
      begin
        edge_reg <= edge_n;
        if (edge_n <= `SSP_EDGES)
          sck_reg <= ~sck_reg;
      end
      if (s_ev & ~word_done)
        busy_reg <= 1'b1;
      if (word_done & slave)
      begin
        busy_reg <= 1'b0;
        pend_reg <= 1'b0;
      end
      if (m_done)
      begin
        busy_reg <= 1'b0;
        pend_reg <= 1'b0;
      end
      if (load)
      begin
        tx_reg <= load_data;
        shift_reg <= load_data;
        sdo_reg <= load_data[7];
        optr_reg <= cke_reg ? 3'h6 : 3'h7;
        pend_reg <= slave;
        busy_reg <= master;
        edge_reg <= 5'h00;
        div_reg <= 7'h00;
        icnt_reg <= 3'h0;
      end
      if (~busy_reg | ~master)
        sck_reg <= cpol;
      if (~en | (slave & use_ss & ss_n_q))
      begin
        busy_reg <= 1'b0;
        icnt_reg <= 3'h0;
        optr_reg <= cke_reg ? 3'h6 : 3'h7;
        sdo_reg <= tx_reg[7];
      end
    end
  end

  assign s_axi_awready = ~aw_ok_reg;
  assign s_axi_wready = ~w_ok_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign sck_o = sck_reg;
  assign sck_oe = en & master;
  assign sdo_o = sdo_reg;
  assign sdo_oe = en & (master | (slave & ~(use_ss & ss_n_q)));
endmodule

//--- shared/ssp_regs.vh
/*
  register map, field positions, reset values and timing counts
  of the spi serial port block. assumes nothing; definitions only.
*/
`ifndef SSP_REGS_VH
`define SSP_REGS_VH

// byte offsets on the register bus
`define SSP_OFF_STATUS 8'h00
`define SSP_OFF_CONTROL 8'h04
`define SSP_OFF_BUFFER 8'h08
`define SSP_OFF_FLAGS 8'h0c
`define SSP_OFF_QUEUE 8'h10

// status fields
`define SSP_ST_SAMPLE 7
`define SSP_ST_EDGE 6
`define SSP_ST_STOP 4
`define SSP_ST_FULL 0

// control fields
`define SSP_CT_WRITE_COLLISION 7
`define SSP_CT_OVF 6
`define SSP_CT_EN 5
`define SSP_CT_CPOL 4
`define SSP_CT_MODE_HI 3
`define SSP_CT_MODE_LO 0

// flags fields
`define SSP_FL_IRQ 0
`define SSP_FL_BUSY 1
`define SSP_FL_LVL_LO 4

// reset values
`define SSP_RST_STATUS 8'h00
`define SSP_RST_CONTROL 8'h00
`define SSP_RST_PINS 3'b101

// port modes
`define SSP_MODE_DIV4 4'h0
`define SSP_MODE_DIV16 4'h1
`define SSP_MODE_DIV64 4'h2
`define SSP_MODE_DIV128 4'h3
`define SSP_MODE_SLV_SS 4'h4
`define SSP_MODE_SLV_NOSS 4'h5

// half bit period minus one, in clk cycles
`define SSP_HALF_DIV4 7'h01
`define SSP_HALF_DIV16 7'h07
`define SSP_HALF_DIV64 7'h1f
`define SSP_HALF_DIV128 7'h3f

// master edge numbering
`define SSP_EDGES 5'h10
`define SSP_EDGES_END 5'h11
`define SSP_FIRST_END_SAMPLE 5'h03

// bus responses
`define SSP_RESP_OKAY 2'b00
`define SSP_RESP_SLVERR 2'b10

// transmit queue
`define SSP_FIFO_WIDTH 8
`define SSP_FIFO_DEPTH 8
`define SSP_FIFO_AW 3

`endif

//--- hw/ssp_sync.v
/*
  three flop pin synchroniser; output follows once stages two and
  three agree. assumes inputs asynchronous to clk.
*/
`timescale 1ns/10ps
module ssp_sync #(
  parameter WIDTH = 3,
  parameter [WIDTH-1:0] RESET_VAL = 0
)(
  input wire clk,
  input wire resetn,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg q_reg;
      always @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1_reg <= RESET_VAL[i];
          s2_reg <= RESET_VAL[i];
          s3_reg <= RESET_VAL[i];
          q_reg <= RESET_VAL[i];
        end
        else
        begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg)
            q_reg <= s3_reg;
        end
      end
      assign dout[i] = q_reg;
    end
  endgenerate
endmodule

//--- hw/ssp_fifo.v
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock; out_data is valid while out_valid is high.
*/
`timescale 1ns/10ps
module ssp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
)(
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rptr_reg];
  assign level = cnt_reg;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (push)
      mem[wptr_reg] <= in_data;
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (push & ~pop)
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      else if (pop & ~push)
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule

//--- verification/ssp_chk_sva.sv
/*
  port assertions for ssp_top, bound at its top.
  assumes one clock domain and async active-low reset.
*/
`timescale 1ns/10ps
`include "ssp_regs.vh"
module ssp_chk (
  input wire clk,
  input wire resetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire sck_o,
  input wire sck_oe,
  input wire sdo_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  chk_pins_together: assert property (sck_oe |-> sdo_oe)
    else $error("data pin not driven in master");
  chk_sck_half_min: assert property (
    sck_oe && $changed(sck_o) |=> $stable(sck_o))
    else $error("serial clock half too short");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_aw_block: assert property (s_axi_awvalid && s_axi_awready
    |=> !s_axi_awready)
    else $error("second address taken");
  chk_w_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr != `SSP_OFF_QUEUE |=> ##1 s_axi_bvalid)
    else $error("write response late");
  chk_rd_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_err_zero: assert property (s_axi_rvalid
    && s_axi_rresp == `SSP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_err: cover property (s_axi_rvalid && s_axi_rresp != 2'h0);
  cov_shift: cover property (sck_oe && $changed(sck_o));
  cov_slave: cover property (sdo_oe && !sck_oe);
endmodule
bind ssp_top ssp_chk i_chk (.*);

//--- verification/ssp_spi_slave.sv
/*
  behavioural spi slave on the master pins.
  assumes go toggles before each fresh word.
*/
`timescale 1ns/10ps
module ssp_spi_slave (
  input wire sck,
  input wire mosi,
  input wire en,
  input wire cpol,
  input wire cke,
  input wire go,
  input wire [7:0] tx,
  output reg miso,
  output reg [7:0] rx
);
  reg [7:0] sh;
  initial miso = 1'b0;
  initial rx = 8'h00;
  // reload; first bit ahead of first edge if cke
  always @(go)
  begin
    sh = tx;
    miso = ~miso;
    if (cke)
    begin
      miso = sh[7];
      sh = {sh[6:0], ~sh[0]};
    end
  end
  // sample on one edge, shift out on the other
  always @(sck)
    if (en)
    begin
      if ((sck != cpol) == cke)
        rx = {rx[6:0], mosi};
      else
      begin
        miso = sh[7];
        sh = {sh[6:0], ~sh[0]};
      end
    end
endmodule

//--- verification/testbench.sv
/*
  self-checking bench, ssp_top as master on a slave model, then as slave driven from the bench.
  assumes ssp_regs.vh on the include path.
*/
`timescale 1ns/10ps
`include "ssp_regs.vh"
module testbench;
  logic clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, sck_i, sck_o;
  logic sck_oe, sdi_i, sdo_o, sdo_oe, ss_n_i, m_cpol, m_cke, m_go;
  logic s_on, sdi_s, m_miso;
  logic [7:0] s_axi_awaddr, s_axi_araddr, m_tx, m_rx, v;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int fail_count, checked;
  ssp_top i_dut (.*);
  ssp_spi_slave i_slv (.sck(sck_o), .mosi(sdo_o), .en(sck_oe),
    .cpol(m_cpol), .cke(m_cke), .go(m_go), .tx(m_tx),
    .miso(m_miso), .rx(m_rx));
  assign sdi_i = s_on ? sdi_s : m_miso;
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      checked++;
      if (s !== e)
      begin
        fail_count++;
        $display("[ERR] %0t seen %h want %h", $time, s, e);
      end
    end
  endtask
  task give_verdict;
    begin
      if (fail_count == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd(input [7:0] a);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(posedge clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wait_idle;
    do
      rd(`SSP_OFF_FLAGS);
    while (d[7:1] !== 7'h0);
  endtask
  task t_regs;
    begin
      rd(`SSP_OFF_STATUS);
      chk(d, 32'h0);
      rd(`SSP_OFF_CONTROL);
      chk(d, 32'h0);
      wr(8'h14, 8'h01);
      chk(r, `SSP_RESP_SLVERR);
      rd(8'h14);
      chk(r, `SSP_RESP_SLVERR);
      chk(d, 32'h0);
      wr(`SSP_OFF_STATUS, 8'hff);
      rd(`SSP_OFF_STATUS);
      chk(d, 32'hc0);
      wr(`SSP_OFF_CONTROL, 8'hcf);
      rd(`SSP_OFF_CONTROL);
      chk(d, 32'hcf);
      chk(sck_oe, 1'b0);
    end
  endtask
  task xfer(input [7:0] st, input [7:0] ct, input [7:0] tx);
    begin
      wr(`SSP_OFF_STATUS, st);
      wr(`SSP_OFF_CONTROL, ct);
      m_cpol <= ct[4];
      m_cke <= st[6];
      m_tx <= ~tx;
      m_go <= ~m_go;
      repeat (4) @(posedge clk);
      chk(sck_o, ct[4]);
      wr(`SSP_OFF_BUFFER, tx);
      wait_idle;
      chk(d[0], 1'b1);
      chk(m_rx, tx);
      rd(`SSP_OFF_STATUS);
      chk(d[0], 1'b1);
      rd(`SSP_OFF_BUFFER);
      chk(d, {24'h0, ~tx});
      rd(`SSP_OFF_STATUS);
      chk(d, {24'h0, st[7:6], 6'h0});
      wr(`SSP_OFF_FLAGS, 8'h01);
      rd(`SSP_OFF_FLAGS);
      chk(d, 32'h0);
    end
  endtask
  task t_fifo;
    int i;
    begin
      m_go <= ~m_go;
      wr(`SSP_OFF_BUFFER, 8'h81);
      wr(`SSP_OFF_BUFFER, 8'h7e);
      rd(`SSP_OFF_CONTROL);
      chk(d, 32'ha1);
      for (i = 0; i < 8; i++)
        wr(`SSP_OFF_QUEUE, 8'h10 + i[7:0]);
      rd(`SSP_OFF_FLAGS);
      chk(d[7:4], 4'h8);
      wr(`SSP_OFF_QUEUE, 8'h55);
      chk(r, `SSP_RESP_OKAY);
      wait_idle;
      chk(m_rx, 8'h55);
      wr(`SSP_OFF_CONTROL, 8'h00);
      rd(`SSP_OFF_CONTROL);
      chk(d, 32'h0);
    end
  endtask
  task s_word(input [7:0] mo, output [7:0] mi);
    int k;
    begin
      ss_n_i <= 1'b0;
      repeat (8) @(posedge clk);
      chk(sdo_oe, 1'b1);
      chk(sck_oe, 1'b0);
      for (k = 7; k >= 0; k--)
      begin
        sck_i <= 1'b1;
        sdi_s <= mo[k];
        repeat (4) @(posedge clk);
        sck_i <= 1'b0;
        repeat (4) @(posedge clk);
        mi[k] = sdo_o;
      end
      repeat (8) @(posedge clk);
      ss_n_i <= 1'b1;
      repeat (8) @(posedge clk);
      chk(sdo_oe, 1'b0);
    end
  endtask
  task t_slave;
    begin
      s_on <= 1'b1;
      sck_i <= 1'b0;
      wr(`SSP_OFF_STATUS, 8'h00);
      wr(`SSP_OFF_CONTROL, 8'h24);
      rd(`SSP_OFF_BUFFER);
      wr(`SSP_OFF_BUFFER, 8'ha6);
      rd(`SSP_OFF_BUFFER);
      chk(d, 32'ha6);
      s_word(8'h3c, v);
      chk(v, 8'ha6);
      rd(`SSP_OFF_STATUS);
      chk(d, 32'h01);
      rd(`SSP_OFF_BUFFER);
      chk(d, 32'h3c);
      wr(`SSP_OFF_BUFFER, 8'h5a);
      s_word(8'hc3, v);
      chk(v, 8'h5a);
      s_word(8'h0f, v);
      chk(v, 8'h5a);
      rd(`SSP_OFF_CONTROL);
      chk(d, 32'h64);
      rd(`SSP_OFF_BUFFER);
      chk(d, 32'hc3);
    end
  endtask
  initial
  begin
    int i;
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, m_go} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {m_cpol, m_cke, m_tx} = 10'h0;
    {s_on, sdi_s} = 2'h0;
    {sck_i, ss_n_i, s_axi_wstrb} = 6'h31;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs;
    for (i = 0; i < 4; i++)
      xfer({1'b0, i[0], 6'h0}, {3'h1, i[1], 4'(i % 3 + 1)},
        8'ha5 + i[7:0]);
    xfer(8'hc0, 8'h21, 8'h96);
    t_fifo;
    t_slave;
    give_verdict;
  end
  initial
  begin
    #2000000;
    fail_count++;
    give_verdict;
  end
endmodule
